/* File: shared/timers_defines.vh */
`ifndef TIMERS_DEFINES_VH
`define TIMERS_DEFINES_VH

// Register byte offsets on the Avalon-MM slave.
`define OFS_RTOS_LOAD      6'h00
`define OFS_RTOS_COUNT     6'h04
`define OFS_RTOS_CONTROL   6'h08
`define OFS_RTOS_IRQ_CLR   6'h0c
`define OFS_GP_LOAD        6'h10
`define OFS_GP_COUNT       6'h14
`define OFS_GP_CONTROL     6'h18
`define OFS_GP_IRQ_CLR     6'h1c
`define OFS_GP_CAPTURE     6'h20
`define OFS_WAKE_LOAD      6'h24
`define OFS_WAKE_COUNT     6'h28
`define OFS_WAKE_CONTROL   6'h2c
`define OFS_WAKE_IRQ_CLR   6'h30

// Control field positions shared by the timers.
`define CTL_ENABLE_BIT     7
`define CTL_PERIODIC_BIT   6
`define CTL_COUNT_UP_BIT   8
`define RTOS_PRESC_HI      3
`define RTOS_PRESC_LO      2
`define GP_PRESC_HI        3
`define GP_PRESC_LO        0
`define GP_FMT_HI          5
`define GP_FMT_LO          4
`define GP_CLKSEL_HI       11
`define GP_CLKSEL_LO       9
`define GP_EVSEL_HI        16
`define GP_EVSEL_LO        12
`define GP_CAPEN_BIT       17

// Writable bits of each control register; the rest read as zero.
`define RTOS_CTL_MASK      32'h0000_00cc
`define GP_CTL_MASK        32'h0003_ffff
`define WAKE_CTL_MASK      32'h0000_01cf
`define CTL_RESET          32'h0000_0000

// Prescaler ratio codes and the last count of each ratio.
`define RATIO_DIV1         2'h0
`define RATIO_DIV16        2'h1
`define RATIO_DIV256       2'h2
`define RATIO_DIV32768     2'h3
`define LAST_DIV1          15'h0000
`define LAST_DIV16         15'h000f
`define LAST_DIV256        15'h00ff
`define LAST_DIV32768      15'h7fff

// Four-bit prescale codes of the 32-bit timers.
`define PRESC4_DIV16       4'h4
`define PRESC4_DIV256      4'h8
`define PRESC4_DIV32768    4'hf

// Clock source codes of the general-purpose timer.
`define SRC_CORE           3'h0
`define SRC_OSC            3'h1
`define SRC_GPIO_A         3'h2
`define SRC_GPIO_B         3'h3

// Event numbering offset against interrupt bit numbers.
`define EVENT_OFFSET       6'h02

// Full-scale values and time-format limits.
`define RTOS_FULL          16'hffff
`define BIN_FULL           32'hffff_ffff
`define HOURS_MAX_SHORT    8'h17
`define HOURS_MAX_LONG     8'hff
`define MIN_SEC_MAX        8'h3b
`define HUNDREDTHS_MAX     8'h63

`endif

/* File: rtl/tick_prescaler.v */
`include "timers_defines.vh"
`default_nettype none

module tick_prescaler
(
    // Clock and reset.
    input  wire        clk,
    input  wire        rst_n,
    // Source pulses and division.
    input  wire        src_tick,
    input  wire [1:0]  ratio,
    input  wire        run,
    // Divided pulse.
    output wire        tick
);

    reg  [14:0] cnt_reg;
    reg  [14:0] cnt_next;
    reg  [14:0] last;

    always @*
    begin
        case (ratio)
            `RATIO_DIV16:    last = `LAST_DIV16;
            `RATIO_DIV256:   last = `LAST_DIV256;
            `RATIO_DIV32768: last = `LAST_DIV32768;
            default:         last = `LAST_DIV1;
        endcase
    end

    assign tick = run & src_tick & (cnt_reg == last);

    always @*
    begin
        cnt_next = cnt_reg;
        if (!run)
            cnt_next = 15'h0000;
        else if (src_tick)
            cnt_next = (cnt_reg >= last) ? 15'h0000 : cnt_reg + 15'h0001;
    end

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            cnt_reg <= 15'h0000;
        else
            cnt_reg <= cnt_next;
    end

endmodule // tick_prescaler

`default_nettype wire

/* File: rtl/general_purpose_timers.v */
// Operation
// - Free-running: down from maximum to zero, or up from zero to full scale, then restart.
// - Periodic: start at load value, run to zero or full scale, reload, continue.
// - Current count readable through the value register at any time.
// - Interrupt request each time count reaches zero (down) or full scale (up).
// - Any write to a timer's interrupt-clear register clears its pending request.
// - First timer: 16-bit down counter from core clock, prescale 1, 16 or 256.
// - Control bit 7 enables counting; cleared after reset.
// - Control bit 6 selects periodic; free-running after reset.
// - First timer prescale bits 3-2: 00 /1, 01 /16, 10 /256, 11 as 00.
// - First timer load and value are 16-bit; value is read-only.
// - Second timer: 32-bit up or down counter behind a programmable prescaler.
// - Second timer bit 8 selects counting up; down after reset.
// - Clock select bits 11-9: core, oscillator, GPIO A rise, GPIO B rise.
// - Second timer prescale bits 3-0: 0000 /1, 0100 /16, 1000 /256, 1111 /32768.
// - Format bits 5-4: binary, reserved, time wrapping 23 h, time wrapping 255 h.
// - Each rising edge of selected interrupt source latches count into read-only capture.
// - Second timer bit 17 enables event capture.
// - Event select bits 16-12 equal the source's interrupt bit number minus 2.
// - Second timer drives a trigger that can start conversions.
// - Wake-up timer counts only oscillator edges, independent of core activity.
// - Wake-up timer: 32-bit up or down, prescale 1, 16, 256 or 32768.
// - Interrupt request stays asserted until software clears it.
`include "timers_defines.vh"
`default_nettype none

module general_purpose_timers
(
    // Clock and reset.
    input  wire        clk,
    input  wire        rst_n,
    // Avalon-MM register slave.
    input  wire [5:0]  address,
    input  wire        read,
    input  wire        write,
    input  wire [31:0] writedata,
    input  wire [3:0]  byteenable,
    output reg  [31:0] readdata,
    output wire        waitrequest,
    // Asynchronous clock inputs.
    input  wire        osc_32k,
    input  wire        gpio_clock_input_a,
    input  wire        gpio_clock_input_b,
    // Interrupt sources by interrupt bit number, same clock domain.
    input  wire [31:0] event_sources,
    // Interrupt requests and conversion trigger.
    output reg         rtos_timer_irq,
    output reg         gp_timer_irq,
    output reg         wakeup_timer_irq,
    output reg         adc_trigger
);

    reg  [15:0] rtos_timer_load;
    reg  [15:0] rtos_timer_count;
    reg  [31:0] rtos_timer_control;
    reg  [31:0] gp_timer_load;
    reg  [31:0] gp_timer_count;
    reg  [31:0] gp_timer_control;
    reg  [31:0] gp_timer_capture;
    reg  [31:0] wake_timer_load;
    reg  [31:0] wake_timer_count;
    reg  [31:0] wake_timer_control;
    reg         ack_reg;
    reg  [2:0]  meta_reg;
    reg  [2:0]  sync_reg;
    reg  [2:0]  prev_reg;
    reg         event_prev_reg;

    function [31:0] merge_bytes;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0]  be;
        integer      i;
        begin
            for (i = 0; i < 4; i = i + 1)
                merge_bytes[i*8 +: 8] = be[i] ? new_val[i*8 +: 8] : old_val[i*8 +: 8];
        end
    endfunction

    function [1:0] ratio4;
        input [3:0] code;
        begin
            case (code)
                `PRESC4_DIV16:    ratio4 = `RATIO_DIV16;
                `PRESC4_DIV256:   ratio4 = `RATIO_DIV256;
                `PRESC4_DIV32768: ratio4 = `RATIO_DIV32768;
                default:          ratio4 = `RATIO_DIV1;
            endcase
        end
    endfunction

    // Steps an hours:minutes:seconds:hundredths value by one hundredth.
    function [31:0] time_step;
        input [31:0] v;
        input        up;
        input [7:0]  hmax;
        reg   [7:0]  h;
        reg   [7:0]  m;
        reg   [7:0]  s;
        reg   [7:0]  c;
        begin
            h = v[31:24];
            m = v[23:16];
            s = v[15:8];
            c = v[7:0];
            if (up)
            begin
                if (c >= `HUNDREDTHS_MAX)
                begin
                    c = 8'h00;
                    if (s >= `MIN_SEC_MAX)
                    begin
                        s = 8'h00;
                        if (m >= `MIN_SEC_MAX)
                        begin
                            m = 8'h00;
                            h = (h >= hmax) ? 8'h00 : h + 8'h01;
                        end
                        else
                            m = m + 8'h01;
                    end
                    else
                        s = s + 8'h01;
                end
                else
                    c = c + 8'h01;
            end
            else
            begin
                if (c == 8'h00)
                begin
                    c = `HUNDREDTHS_MAX;
                    if (s == 8'h00)
                    begin
                        s = `MIN_SEC_MAX;
                        if (m == 8'h00)
                        begin
                            m = `MIN_SEC_MAX;
                            h = (h == 8'h00) ? hmax : h - 8'h01;
                        end
                        else
                            m = m - 8'h01;
                    end
                    else
                        s = s - 8'h01;
                end
                else
                    c = c - 8'h01;
            end
            time_step = {h, m, s, c};
        end
    endfunction

    // Bus handshake: one wait cycle, then the request is taken.
    wire        wr_en = write & ack_reg;
    assign waitrequest = (read | write) & ~ack_reg;

    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_reg  <= 1'b0;
            readdata <= 32'h0000_0000;
        end
        else
        begin
            ack_reg <= (read | write) & ~ack_reg;
            if (read & ~ack_reg)
            begin
                case (address)
                    `OFS_RTOS_LOAD:    readdata <= {16'h0000, rtos_timer_load};
                    `OFS_RTOS_COUNT:   readdata <= {16'h0000, rtos_timer_count};
                    `OFS_RTOS_CONTROL: readdata <= rtos_timer_control;
                    `OFS_GP_LOAD:      readdata <= gp_timer_load;
                    `OFS_GP_COUNT:     readdata <= gp_timer_count;
                    `OFS_GP_CONTROL:   readdata <= gp_timer_control;
                    `OFS_GP_CAPTURE:   readdata <= gp_timer_capture;
                    `OFS_WAKE_LOAD:    readdata <= wake_timer_load;
                    `OFS_WAKE_COUNT:   readdata <= wake_timer_count;
                    `OFS_WAKE_CONTROL: readdata <= wake_timer_control;
                    default:           readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Pin inputs: two stages, then a third for edge detection.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_reg <= 3'h0;
            sync_reg <= 3'h0;
            prev_reg <= 3'h0;
        end
        else
        begin
            meta_reg <= {gpio_clock_input_b, gpio_clock_input_a, osc_32k};
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    wire [2:0]  rise = sync_reg & ~prev_reg;

    // Control registers with read-back of the writable fields only.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rtos_timer_control <= `CTL_RESET;
            gp_timer_control   <= `CTL_RESET;
            wake_timer_control <= `CTL_RESET;
        end
        else if (wr_en)
        begin
            if (address == `OFS_RTOS_CONTROL)
                rtos_timer_control <= merge_bytes(rtos_timer_control, writedata,
                                                  byteenable) & `RTOS_CTL_MASK;
            if (address == `OFS_GP_CONTROL)
                gp_timer_control <= merge_bytes(gp_timer_control, writedata,
                                                byteenable) & `GP_CTL_MASK;
            if (address == `OFS_WAKE_CONTROL)
                wake_timer_control <= merge_bytes(wake_timer_control, writedata,
                                                  byteenable) & `WAKE_CTL_MASK;
        end
    end

    // Prescaled count ticks.
    wire        rtos_run = rtos_timer_control[`CTL_ENABLE_BIT];
    wire        gp_run   = gp_timer_control[`CTL_ENABLE_BIT];
    wire        wake_run = wake_timer_control[`CTL_ENABLE_BIT];
    wire        rtos_tick;
    wire        gp_tick;
    wire        wake_tick;
    reg         gp_src;
    reg  [1:0]  rtos_ratio;

    always @*
    begin
        case (rtos_timer_control[`RTOS_PRESC_HI:`RTOS_PRESC_LO])
            2'h1:    rtos_ratio = `RATIO_DIV16;
            2'h2:    rtos_ratio = `RATIO_DIV256;
            default: rtos_ratio = `RATIO_DIV1;
        endcase
    end

    always @*
    begin
        case (gp_timer_control[`GP_CLKSEL_HI:`GP_CLKSEL_LO])
            `SRC_CORE:   gp_src = 1'b1;
            `SRC_OSC:    gp_src = rise[0];
            `SRC_GPIO_A: gp_src = rise[1];
            `SRC_GPIO_B: gp_src = rise[2];
            default:     gp_src = 1'b0;
        endcase
    end

    tick_prescaler rtos_presc
    (
        .clk      (clk),
        .rst_n    (rst_n),
        .src_tick (1'b1),
        .ratio    (rtos_ratio),
        .run      (rtos_run),
        .tick     (rtos_tick)
    );

    tick_prescaler gp_presc
    (
        .clk      (clk),
        .rst_n    (rst_n),
        .src_tick (gp_src),
        .ratio    (ratio4(gp_timer_control[`GP_PRESC_HI:`GP_PRESC_LO])),
        .run      (gp_run),
        .tick     (gp_tick)
    );

    tick_prescaler wake_presc
    (
        .clk      (clk),
        .rst_n    (rst_n),
        .src_tick (rise[0]),
        .ratio    (ratio4(wake_timer_control[`GP_PRESC_HI:`GP_PRESC_LO])),
        .run      (wake_run),
        .tick     (wake_tick)
    );

    // Next count and wrap events of each timer.
    wire        rtos_periodic = rtos_timer_control[`CTL_PERIODIC_BIT];
    wire        gp_periodic   = gp_timer_control[`CTL_PERIODIC_BIT];
    wire        gp_up         = gp_timer_control[`CTL_COUNT_UP_BIT];
    wire        gp_time       = gp_timer_control[`GP_FMT_HI];
    wire [7:0]  gp_hmax       = gp_timer_control[`GP_FMT_LO] ? `HOURS_MAX_LONG
                                                             : `HOURS_MAX_SHORT;
    wire [31:0] gp_full       = gp_time ? {gp_hmax, `MIN_SEC_MAX, `MIN_SEC_MAX,
                                           `HUNDREDTHS_MAX} : `BIN_FULL;
    wire        wake_periodic = wake_timer_control[`CTL_PERIODIC_BIT];
    wire        wake_up       = wake_timer_control[`CTL_COUNT_UP_BIT];
    wire        rtos_wrap     = rtos_tick & (rtos_timer_count == 16'h0000);
    wire        gp_wrap       = gp_tick & (gp_timer_count == (gp_up ? gp_full
                                                                    : 32'h0000_0000));
    wire        wake_wrap     = wake_tick & (wake_timer_count == (wake_up ? `BIN_FULL
                                                                         : 32'h0000_0000));
    reg  [15:0] rtos_count_next;
    reg  [31:0] gp_count_next;
    reg  [31:0] wake_count_next;

    always @*
    begin
        rtos_count_next = rtos_timer_count;
        if (wr_en & (address == `OFS_RTOS_LOAD))
            rtos_count_next = writedata[15:0];
        else if (rtos_wrap)
            rtos_count_next = rtos_periodic ? rtos_timer_load : `RTOS_FULL;
        else if (rtos_tick)
            rtos_count_next = rtos_timer_count - 16'h0001;
    end

    always @*
    begin
        gp_count_next = gp_timer_count;
        if (wr_en & (address == `OFS_GP_LOAD))
            gp_count_next = writedata;
        else if (gp_wrap)
            gp_count_next = gp_periodic ? gp_timer_load
                                        : (gp_up ? 32'h0000_0000 : gp_full);
        else if (gp_tick & gp_time)
            gp_count_next = time_step(gp_timer_count, gp_up, gp_hmax);
        else if (gp_tick)
            gp_count_next = gp_up ? gp_timer_count + 32'h0000_0001
                                  : gp_timer_count - 32'h0000_0001;
    end

    always @*
    begin
        wake_count_next = wake_timer_count;
        if (wr_en & (address == `OFS_WAKE_LOAD))
            wake_count_next = writedata;
        else if (wake_wrap)
            wake_count_next = wake_periodic ? wake_timer_load
                                            : (wake_up ? 32'h0000_0000 : `BIN_FULL);
        else if (wake_tick)
            wake_count_next = wake_up ? wake_timer_count + 32'h0000_0001
                                      : wake_timer_count - 32'h0000_0001;
    end

    // Capture source: field value plus two gives the interrupt bit number.
    wire [5:0]  event_index = {1'b0, gp_timer_control[`GP_EVSEL_HI:`GP_EVSEL_LO]}
                              + `EVENT_OFFSET;
    wire        event_now   = (event_index < 6'h20) ? event_sources[event_index[4:0]]
                                                    : 1'b0;
    wire        event_rise  = event_now & ~event_prev_reg;

    // Loading a timer also restarts its count from the new value.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rtos_timer_load  <= 16'h0000;
            rtos_timer_count <= 16'h0000;
            gp_timer_load    <= 32'h0000_0000;
            gp_timer_count   <= 32'h0000_0000;
            gp_timer_capture <= 32'h0000_0000;
            wake_timer_load  <= 32'h0000_0000;
            wake_timer_count <= 32'h0000_0000;
            event_prev_reg   <= 1'b0;
        end
        else
        begin
            if (wr_en & (address == `OFS_RTOS_LOAD))
                rtos_timer_load <= writedata[15:0];
            if (wr_en & (address == `OFS_GP_LOAD))
                gp_timer_load <= writedata;
            if (wr_en & (address == `OFS_WAKE_LOAD))
                wake_timer_load <= writedata;
            rtos_timer_count <= rtos_count_next;
            gp_timer_count   <= gp_count_next;
            wake_timer_count <= wake_count_next;
            event_prev_reg   <= event_now;
            if (event_rise & gp_timer_control[`GP_CAPEN_BIT])
                gp_timer_capture <= gp_timer_count;
        end
    end

    // A wrap in the same cycle as a clear keeps the request pending.
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rtos_timer_irq   <= 1'b0;
            gp_timer_irq     <= 1'b0;
            wakeup_timer_irq <= 1'b0;
            adc_trigger      <= 1'b0;
        end
        else
        begin
            rtos_timer_irq   <= rtos_wrap | (rtos_timer_irq
                                & ~(wr_en & (address == `OFS_RTOS_IRQ_CLR)));
            gp_timer_irq     <= gp_wrap | (gp_timer_irq
                                & ~(wr_en & (address == `OFS_GP_IRQ_CLR)));
            wakeup_timer_irq <= wake_wrap | (wakeup_timer_irq
                                & ~(wr_en & (address == `OFS_WAKE_IRQ_CLR)));
            adc_trigger      <= gp_wrap;
        end
    end

endmodule // general_purpose_timers

`default_nettype wire

/* File: sim/timers_monitor.sv */
`include "timers_defines.vh"
`default_nettype none

module timers_monitor
(
    // Clock and reset.
    input wire logic       clk,
    input wire logic       rst_n,
    // Register bus.
    input wire logic [5:0] address,
    input wire logic       read,
    input wire logic       write,
    input wire logic       waitrequest,
    // Requests and trigger.
    input wire logic       rtos_timer_irq,
    input wire logic       gp_timer_irq,
    input wire logic       wakeup_timer_irq,
    input wire logic       adc_trigger
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // A clear counts only at the edge where the bus stops waiting.
    // The trigger and the request are both registered from the same wrap.
    wire wr_done = write && !waitrequest;
    wire clr_rtos = wr_done && address == `OFS_RTOS_IRQ_CLR;
    wire clr_gp = wr_done && address == `OFS_GP_IRQ_CLR;
    wire clr_wake = wr_done && address == `OFS_WAKE_IRQ_CLR;

    AST_WAIT_FIRST:
        assert property (($rose(read) || $rose(write)) |-> waitrequest)
        else $error("request taken without a wait cycle");
    AST_WAIT_ONE:
        assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("more than one wait cycle");
    AST_IDLE_NO_WAIT:
        assert property (!(read || write) |-> !waitrequest)
        else $error("wait raised while idle");
    AST_RESET_QUIET:
        assert property ($rose(rst_n) |-> !(rtos_timer_irq || gp_timer_irq || wakeup_timer_irq
                                             || adc_trigger))
        else $error("output active after reset");
    AST_RTOS_IRQ_HOLD:
        assert property ($fell(rtos_timer_irq) |-> $past(clr_rtos))
        else $error("rtos request dropped without clear");
    AST_GP_IRQ_HOLD:
        assert property ($fell(gp_timer_irq) |-> $past(clr_gp))
        else $error("gp request dropped without clear");
    AST_WAKE_IRQ_HOLD:
        assert property ($fell(wakeup_timer_irq) |-> $past(clr_wake))
        else $error("wake request dropped without clear");
    AST_IRQ_THEN_ADC:
        assert property ($rose(gp_timer_irq) |-> adc_trigger)
        else $error("no trigger after wrap");

    cover property ($rose(rtos_timer_irq));
    cover property ($rose(wakeup_timer_irq));
    cover property (adc_trigger);
endmodule // timers_monitor

bind general_purpose_timers timers_monitor i_mon (.clk, .rst_n, .address, .read, .write,
    .waitrequest, .rtos_timer_irq, .gp_timer_irq, .wakeup_timer_irq, .adc_trigger);

`default_nettype wire

/* File: sim/clock_pin_model.sv */
`default_nettype none

module clock_pin_model
(
    // Clock and reset.
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Requests and pins: oscillator, GPIO A, GPIO B.
    input  wire logic [2:0] fire,
    output wire logic [2:0] pins
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] hold_reg [3];

    // A request gives one four-cycle pulse; a pin stays low between pulses.
    always_ff @(posedge clk or negedge rst_n)
    begin
        for (int i = 0; i < 3; i++)
            if (!rst_n)
                hold_reg[i] <= 4'h0;
            else
                hold_reg[i] <= {hold_reg[i][2:0], fire[i]};
    end

    assign pins = {|hold_reg[2], |hold_reg[1], |hold_reg[0]};
endmodule // clock_pin_model

`default_nettype wire

/* File: sim/tb.sv */
`include "timers_defines.vh"
`default_nettype none

`define CHK(nm, e, g) \
    begin \
        total_checks++; \
        if ((g) !== (e)) \
        begin \
            n_fail++; \
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g); \
        end \
    end

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk;
    logic        rst_n = 1'b0;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [5:0]  address = 6'h00;
    logic [31:0] writedata = 32'h0;
    logic [3:0]  byteenable = 4'hf;
    logic [31:0] event_sources = 32'h0;
    logic [2:0]  fire = 3'h0;
    logic [31:0] readdata, q;
    logic [2:0]  pins, irqs;
    logic        waitrequest, adc_trigger, rtos_timer_irq, gp_timer_irq, wakeup_timer_irq;
    logic [5:0]  ld_of [3] = '{`OFS_RTOS_LOAD, `OFS_GP_LOAD, `OFS_WAKE_LOAD};
    logic [5:0]  ctl_of [3] = '{`OFS_RTOS_CONTROL, `OFS_GP_CONTROL, `OFS_WAKE_CONTROL};
    logic [5:0]  clr_of [3] = '{`OFS_RTOS_IRQ_CLR, `OFS_GP_IRQ_CLR, `OFS_WAKE_IRQ_CLR};
    int          n_fail = 0;
    int          total_checks = 0;
    int          n;

    assign irqs = {wakeup_timer_irq, gp_timer_irq, rtos_timer_irq};

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    general_purpose_timers i_dut
    (
        .clk, .rst_n, .address, .read, .write, .writedata, .byteenable, .readdata,
        .waitrequest, .osc_32k(pins[0]), .gpio_clock_input_a(pins[1]),
        .gpio_clock_input_b(pins[2]), .event_sources, .rtos_timer_irq, .gp_timer_irq,
        .wakeup_timer_irq, .adc_trigger
    );
    clock_pin_model i_pins (.clk, .rst_n, .fire, .pins);

    task automatic results;
        $display("Checks made %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        address <= a;
        writedata <= d;
        write <= w;
        read <= !w;
        for (k = 0; k < 20; k++)
        begin
            @(posedge clk);
            if (waitrequest === 1'b0)
                break;
        end
        if (k == 20)
        begin
            n_fail++;
            results();
        end
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0);
        `CHK(nm, e, q)
    endtask

    task automatic pulse(input logic pin, input int i);
        @(posedge clk);
        if (pin)
            fire <= 3'(1 << i);
        else
            event_sources <= 32'h1 << i;
        @(posedge clk);
        fire <= 3'h0;
        event_sources <= 32'h0;
        repeat (12) @(posedge clk);
        #1;
    endtask

    task automatic run(input int i, input logic [31:0] ctl, ld, input int e);
        bus(1'b1, ld_of[i], ld);
        bus(1'b1, ctl_of[i], ctl);
        n = 0;
        do
        begin
            @(posedge clk);
            #1;
            n++;
        end
        while (irqs[i] !== 1'b1 && n < e + 20);
        `CHK("cycles to request", e, n)
        `CHK("trigger", i == 1, adc_trigger)
        bus(1'b1, ctl_of[i], 32'h0);
        `CHK("request held", 1'b1, irqs[i])
        bus(1'b1, clr_of[i], 32'h0000_005a);
        #1;
        `CHK("request cleared", 1'b0, irqs[i])
    endtask

    initial
    begin
        #1_000_000;
        n_fail++;
        results();
    end

    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 3; i++)
            rd_chk(ctl_of[i], 32'h0, "control reset");
        bus(1'b1, `OFS_RTOS_LOAD, 32'hdead_beef);
        rd_chk(`OFS_RTOS_LOAD, 32'h0000_beef, "rtos load");
        bus(1'b1, `OFS_RTOS_COUNT, 32'h1);
        rd_chk(`OFS_RTOS_COUNT, 32'h0000_beef, "rtos count");
        bus(1'b1, `OFS_RTOS_CONTROL, 32'hffff_ff7f);
        rd_chk(`OFS_RTOS_CONTROL, 32'h0000_004c, "rtos control");
        bus(1'b1, `OFS_GP_CONTROL, 32'hffff_ff7f);
        rd_chk(`OFS_GP_CONTROL, 32'h0003_ff7f, "gp control");
        rd_chk(6'h34, 32'h0, "unmapped");
        $display("register test done");
        bus(1'b1, `OFS_GP_LOAD, 32'h0000_1357);
        bus(1'b1, `OFS_GP_CONTROL, 32'h0002_3000);
        pulse(1'b0, 4);
        rd_chk(`OFS_GP_CAPTURE, 32'h0, "capture other");
        pulse(1'b0, 5);
        rd_chk(`OFS_GP_CAPTURE, 32'h0000_1357, "capture");
        bus(1'b1, `OFS_GP_LOAD, 32'h003b_3b63);
        bus(1'b1, `OFS_GP_CONTROL, 32'h0000_05a0);
        pulse(1'b1, 1);
        rd_chk(`OFS_GP_COUNT, 32'h0100_0000, "time carry");
        $display("capture and format test done");
        for (int s = 1; s < 4; s++)
        begin
            bus(1'b1, `OFS_GP_LOAD, 32'h2);
            bus(1'b1, `OFS_WAKE_LOAD, 32'h2);
            bus(1'b1, `OFS_GP_CONTROL, 32'(s << 9) | 32'hc0);
            bus(1'b1, `OFS_WAKE_CONTROL, 32'hc0);
            for (int p = 0; p < 3; p++)
            begin
                `CHK("early pin tick", 1'b0, gp_timer_irq)
                pulse(1'b1, s - 1);
            end
            `CHK("pin tick", 1'b1, gp_timer_irq)
            `CHK("wake tick", s == 1, wakeup_timer_irq)
            rd_chk(`OFS_GP_COUNT, 32'h2, "running count");
            for (int i = 1; i < 3; i++)
            begin
                bus(1'b1, ctl_of[i], 32'h0);
                bus(1'b1, clr_of[i], 32'h0);
            end
        end
        $display("clock source test done");
        run(0, 32'hc0, 32'h2, 3);
        run(0, 32'hc4, 32'h2, 48);
        run(0, 32'hc8, 32'h2, 768);
        run(0, 32'hcc, 32'h2, 3);
        run(0, 32'h80, 32'h1, 2);
        rd_chk(`OFS_RTOS_COUNT, 32'h0000_fffc, "rtos free restart");
        run(1, 32'hc0, 32'h3, 4);
        run(1, 32'hc4, 32'h1, 32);
        run(1, 32'hc8, 32'h0, 256);
        run(1, 32'hcf, 32'h0, 32768);
        run(1, 32'h80, 32'h1, 2);
        rd_chk(`OFS_GP_COUNT, 32'hffff_fffc, "gp free restart");
        run(1, 32'h1c0, 32'hffff_fffe, 2);
        run(1, 32'h1e0, 32'h173b_3b62, 2);
        run(1, 32'h1f0, 32'hff3b_3b62, 2);
        $display("timer test done");
        results();
    end
endmodule // tb

`default_nettype wire
